//--- srs_seq.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - repeat prefixes never change any flag
// - plain repeat on move or store loops while the counter is nonzero
// - repeat-while-equal shares the plain repeat byte; compare/scan continue on zero set
// - repeat-while-unequal ends repetition when zero flag is set
// - termination uses only the zero flag posted by the element
// - compare/scan stop on counter zero or failed zero test, whichever first
// - interrupts taken between elements; resume with current counter and indexes
// - only the repeat prefix survives an interrupt; override and bus hold dropped
// - non-maskable interrupt accepted even with maskable interrupts disabled
// - move reads at source index, writes at dest index, steps both
// - compare subtracts dest from source, sets six flags, steps both
// - scan subtracts dest element from accumulator, sets flags, steps dest only
// - load copies source element into accumulator, steps source only
// - store writes accumulator to dest element, steps dest only
// - fetch address is code base times 16 plus instruction offset
// - a transfer discards queued bytes and refetches from the new location
// - transfers other than interrupt-related ones leave flags untouched
// - an unconditional transfer always redirects fetching
// - indexes step up on direction zero, down on one, by one or two
// - counter drops by one per repetition; zero count performs no element
// - source in data segment unless overridden; destination always extra segment
module srs_seq
  import srs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // code fetch port
  output logic             code_req,
  output logic [19:0]      code_addr,
  input  wire logic        code_ack,
  input  wire logic [7:0]  code_data,
  // program transfer from the rest of the execution unit
  input  wire logic        xfer_valid,
  input  wire logic [15:0] xfer_code_base,
  input  wire logic [15:0] xfer_instr_offset,
  input  wire logic        xfer_intr_group,
  input  wire logic [5:0]  xfer_flags,
  output logic             queue_flush,
  // element data port
  output logic             mem_req,
  output logic             mem_we,
  output logic [1:0]       mem_seg,
  output logic [15:0]      mem_addr,
  output logic             mem_word,
  output logic [15:0]      mem_wdata,
  output logic             bus_hold,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  // architectural register load
  input  wire logic        reg_load,
  input  wire logic [15:0] load_source_index,
  input  wire logic [15:0] load_dest_index,
  input  wire logic [15:0] load_repeat_counter,
  input  wire logic [15:0] load_accum_word,
  input  wire logic [5:0]  load_flags,
  input  wire logic        direction_flag,
  // interrupts
  input  wire logic        intr_enable,
  input  wire logic        intr_req,
  input  wire logic        nmi_req,
  output logic             intr_take,
  input  wire logic        intr_done,
  // state view
  output logic [15:0]      source_index,
  output logic [15:0]      dest_index,
  output logic [15:0]      repeat_counter,
  output logic [15:0]      accum_word,
  output logic [5:0]       flags,
  output logic [15:0]      code_base,
  output logic [15:0]      instr_offset,
  output logic             busy,
  output logic             other_op,
  output logic [7:0]       other_byte
);
  srs_state_t  state_r;
  srs_rep_t    rep_r;
  srs_prim_t   prim_r;
  logic        word_r;
  logic        seg_ovr_r;
  logic [1:0]  seg_sel_r;
  logic        hold_r;
  logic [15:0] si_r;
  logic [15:0] di_r;
  logic [15:0] cx_r;
  logic [15:0] ax_r;
  logic [5:0]  flags_r;
  logic [15:0] src_val_r;
  logic [15:0] dst_val_r;
  logic [15:0] base_r;
  logic [15:0] ofs_r;
  logic        other_op_r;
  logic [7:0]  other_byte_r;
  logic        buf_in_ready;
  logic        dec_valid;
  logic        dec_ready;
  logic [7:0]  dec_byte;
  logic [5:0]  sub_flags;
  logic [15:0] sub_a;
  logic [15:0] step;
  logic [15:0] cx_nxt;
  logic        uses_src;
  logic        uses_dst_read;
  logic        is_test;
  logic        go_on;
  logic        irq_pend;

  // fetch: physical address from base and offset, held off while a transfer lands
  // fetch address
  assign code_addr   = 20'({base_r, 4'h0}) + 20'(ofs_r);
  assign code_req    = buf_in_ready && !xfer_valid;
  assign queue_flush = xfer_valid;

  // byte queue between fetch and decode; a full queue stalls fetching
  srs_buf2 u_queue (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (xfer_valid),
    .in_valid  (code_req && code_ack),
    .in_ready  (buf_in_ready),
    .in_data   (code_data),
    .out_valid (dec_valid),
    .out_ready (dec_ready),
    .out_data  (dec_byte)
  );

  // code base and offset; a transfer overrides the sequential step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_r <= RST_WORD;
      ofs_r  <= RST_WORD;
    end else if (xfer_valid) begin
      base_r <= xfer_code_base;
      ofs_r  <= xfer_instr_offset;
    end else if (code_req && code_ack) begin
      ofs_r <= ofs_r + FETCH_STEP;
    end
  end

  assign dec_ready     = (state_r == ST_DECODE);
  assign uses_src      = (prim_r == PRIM_MOVE) || (prim_r == PRIM_COMPARE)
                      || (prim_r == PRIM_LOAD);
  assign uses_dst_read = (prim_r == PRIM_COMPARE) || (prim_r == PRIM_SCAN);
  assign is_test       = uses_dst_read;
  assign step          = word_r ? STEP_WORD : STEP_BYTE;
  assign cx_nxt        = (rep_r != REP_NONE) ? cx_r - 16'h0001 : cx_r;
  assign irq_pend      = nmi_req || (intr_req && intr_enable);
  assign sub_a         = (prim_r == PRIM_SCAN) ? ax_r : src_val_r;

  srs_sub_flags u_sub (
    .a     (sub_a),
    .b     (dst_val_r),
    .word  (word_r),
    .flags (sub_flags)
  );

  // continuation test after an element, from the freshly posted zero flag only
  always_comb begin
    // posted zero flag only; first stop wins
    go_on = (rep_r != REP_NONE) && (cx_nxt != 16'h0000);
    if (is_test) begin
      if (rep_r == REP_WHILE_EQ) go_on = go_on && sub_flags[FLG_ZERO];
      if (rep_r == REP_WHILE_NE) go_on = go_on && !sub_flags[FLG_ZERO];
    end
  end

  // element sequencer state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_DECODE;
    end else begin
      unique case (state_r)
        ST_DECODE: begin
          if (dec_valid && (dec_byte[7:1] inside {OP_MOVE, OP_COMPARE, OP_STORE,
                                                  OP_LOAD, OP_SCAN})) begin
            state_r <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if ((rep_r != REP_NONE) && (cx_r == 16'h0000)) state_r <= ST_DECODE;
          else if ((rep_r != REP_NONE) && irq_pend)      state_r <= ST_INTR;
          else if (uses_src)                             state_r <= ST_READ_SRC;
          else if (prim_r == PRIM_SCAN)                  state_r <= ST_READ_DST;
          else                                           state_r <= ST_WRITE;
        end
        ST_READ_SRC: begin
          if (mem_ack) begin
            if (prim_r == PRIM_MOVE)         state_r <= ST_WRITE;
            else if (prim_r == PRIM_COMPARE) state_r <= ST_READ_DST;
            else                             state_r <= ST_UPDATE;
          end
        end
        ST_READ_DST: if (mem_ack) state_r <= ST_UPDATE;
        ST_WRITE:    if (mem_ack) state_r <= ST_UPDATE;
        ST_UPDATE:   state_r <= go_on ? ST_CHECK : ST_DECODE;
        ST_INTR:     if (intr_done) state_r <= ST_CHECK;
      endcase
    end
  end

  // prefix and primitive latch; repeat prefix and primitive kept across an interrupt for re-entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rep_r     <= REP_NONE;
      prim_r    <= PRIM_MOVE;
      word_r    <= 1'b0;
      seg_ovr_r <= 1'b0;
      seg_sel_r <= SEG_DATA;
      hold_r    <= 1'b0;
    end else if (state_r == ST_DECODE && dec_valid) begin
      unique case (dec_byte)
        OP_REP_EQ:   rep_r <= REP_WHILE_EQ;
        OP_REP_NE:   rep_r <= REP_WHILE_NE;
        OP_BUS_HOLD: hold_r <= 1'b1;
        OP_SEG_ES, OP_SEG_CS, OP_SEG_SS, OP_SEG_DS: begin
          seg_ovr_r <= 1'b1;
          seg_sel_r <= dec_byte[4:3];
        end
        default: begin
          word_r <= dec_byte[0];
          unique case (dec_byte[7:1])
            OP_MOVE:    prim_r <= PRIM_MOVE;
            OP_COMPARE: prim_r <= PRIM_COMPARE;
            OP_STORE:   prim_r <= PRIM_STORE;
            OP_LOAD:    prim_r <= PRIM_LOAD;
            OP_SCAN:    prim_r <= PRIM_SCAN;
            default: begin
              // not a string primitive: prefixes do not carry over
              rep_r     <= REP_NONE;
              seg_ovr_r <= 1'b0;
              hold_r    <= 1'b0;
            end
          endcase
        end
      endcase
    end else if (state_r == ST_CHECK && rep_r != REP_NONE && cx_r != 16'h0000 && irq_pend) begin
      // extra prefixes are lost across the interrupt
      seg_ovr_r <= 1'b0;
      hold_r    <= 1'b0;
    end else if ((state_r == ST_CHECK && rep_r != REP_NONE && cx_r == 16'h0000)
                 || (state_r == ST_UPDATE && !go_on)) begin
      rep_r     <= REP_NONE;
      seg_ovr_r <= 1'b0;
      hold_r    <= 1'b0;
    end
  end

  // element port drive
  always_comb begin
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_seg   = SEG_EXTRA;
    mem_addr  = di_r;
    mem_wdata = (prim_r == PRIM_MOVE) ? src_val_r : ax_r;
    unique case (state_r)
      ST_READ_SRC: begin
        mem_req  = 1'b1;
        mem_seg  = seg_ovr_r ? seg_sel_r : SEG_DATA;
        mem_addr = si_r;
      end
      ST_READ_DST: mem_req = 1'b1;
      ST_WRITE: begin
        mem_req = 1'b1;
        mem_we  = 1'b1;
      end
      default: mem_req = 1'b0;
    endcase
  end
  assign mem_word = word_r;
  assign bus_hold = hold_r && mem_req;

  // operand capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_val_r <= RST_WORD;
      dst_val_r <= RST_WORD;
    end else if (mem_ack && state_r == ST_READ_SRC) begin
      src_val_r <= word_r ? mem_rdata : {8'h00, mem_rdata[7:0]};
    end else if (mem_ack && state_r == ST_READ_DST) begin
      dst_val_r <= word_r ? mem_rdata : {8'h00, mem_rdata[7:0]};
    end
  end

  // index, counter and accumulator update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      si_r <= RST_WORD;
      di_r <= RST_WORD;
      cx_r <= RST_WORD;
      ax_r <= RST_WORD;
    end else if (reg_load) begin
      si_r <= load_source_index;
      di_r <= load_dest_index;
      cx_r <= load_repeat_counter;
      ax_r <= load_accum_word;
    end else if (state_r == ST_UPDATE) begin
      cx_r <= cx_nxt;
      // source steps for move, compare, load
      if (uses_src) si_r <= direction_flag ? si_r - step : si_r + step;
      // dest steps for all but load
      if (prim_r != PRIM_LOAD) di_r <= direction_flag ? di_r - step : di_r + step;
      // accumulator load, byte keeps upper half
      if (prim_r == PRIM_LOAD) begin
        ax_r <= word_r ? src_val_r : {ax_r[15:8], src_val_r[7:0]};
      end
    end
  end

  // flags: only register loads, compare and scan elements or interrupt-group transfers write them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= RST_FLAGS;
    end else if (reg_load) begin
      flags_r <= load_flags;
    end else if (xfer_valid && xfer_intr_group) begin
      flags_r <= xfer_flags;
    end else if (state_r == ST_UPDATE && is_test) begin
      // primitive posts flags, prefix never does
      flags_r <= sub_flags;
    end
  end

  // non-string opcodes go on to the execution unit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      other_op_r   <= 1'b0;
      other_byte_r <= 8'h00;
    end else begin
      other_op_r <= 1'b0;
      if (state_r == ST_DECODE && dec_valid
          && !(dec_byte inside {OP_REP_EQ, OP_REP_NE, OP_BUS_HOLD, OP_SEG_ES,
                                OP_SEG_CS, OP_SEG_SS, OP_SEG_DS})
          && !(dec_byte[7:1] inside {OP_MOVE, OP_COMPARE, OP_STORE, OP_LOAD, OP_SCAN})) begin
        other_op_r   <= 1'b1;
        other_byte_r <= dec_byte;
      end
    end
  end

  // acknowledge the interrupt at an element boundary
  assign intr_take      = (state_r == ST_CHECK) && (rep_r != REP_NONE)
                       && (cx_r != 16'h0000) && irq_pend;
  assign busy           = (state_r != ST_DECODE);
  assign source_index   = si_r;
  assign dest_index     = di_r;
  assign repeat_counter = cx_r;
  assign accum_word     = ax_r;
  assign flags          = flags_r;
  assign code_base      = base_r;
  assign instr_offset   = ofs_r;
  assign other_op       = other_op_r;
  assign other_byte     = other_byte_r;
endmodule : srs_seq
`default_nettype wire

//--- srs_pkg.sv
package srs_pkg;
  // prefix and primitive opcode bytes
  localparam logic [7:0] OP_REP_EQ    = 8'hF3; // count_loop_prefix, loop_while_equal/zero
  localparam logic [7:0] OP_REP_NE    = 8'hF2; // loop_while_unequal/nonzero
  localparam logic [7:0] OP_BUS_HOLD  = 8'hF0;
  localparam logic [7:0] OP_SEG_ES    = 8'h26;
  localparam logic [7:0] OP_SEG_CS    = 8'h2E;
  localparam logic [7:0] OP_SEG_SS    = 8'h36;
  localparam logic [7:0] OP_SEG_DS    = 8'h3E;
  localparam logic [6:0] OP_MOVE      = 7'h52; // upper seven bits, bit 0 selects word
  localparam logic [6:0] OP_COMPARE   = 7'h53;
  localparam logic [6:0] OP_STORE     = 7'h55;
  localparam logic [6:0] OP_LOAD      = 7'h56;
  localparam logic [6:0] OP_SCAN      = 7'h57;
  // segment selects on the element port
  localparam logic [1:0] SEG_EXTRA    = 2'h0;
  localparam logic [1:0] SEG_CODE     = 2'h1;
  localparam logic [1:0] SEG_STACK    = 2'h2;
  localparam logic [1:0] SEG_DATA     = 2'h3;
  // flag bit positions inside the six-bit arithmetic flag word
  localparam int FLG_CARRY = 0;
  localparam int FLG_PAR   = 1;
  localparam int FLG_AUX   = 2;
  localparam int FLG_ZERO  = 3;
  localparam int FLG_SIGN  = 4;
  localparam int FLG_OVF   = 5;
  // reset values, step sizes and queue dimensions
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [5:0]  RST_FLAGS   = 6'h00;
  localparam logic [15:0] STEP_BYTE   = 16'h0001;
  localparam logic [15:0] STEP_WORD   = 16'h0002;
  localparam logic [15:0] FETCH_STEP  = 16'h0001;
  localparam int          BUF_DEPTH   = 2;
  localparam int          BUF_WIDTH   = 8;

  typedef enum logic [1:0] {REP_NONE, REP_WHILE_EQ, REP_WHILE_NE} srs_rep_t;
  typedef enum logic [2:0] {PRIM_MOVE, PRIM_COMPARE, PRIM_SCAN, PRIM_LOAD, PRIM_STORE}
    srs_prim_t;
  typedef enum logic [2:0] {ST_DECODE, ST_CHECK, ST_READ_SRC, ST_READ_DST, ST_WRITE,
                            ST_UPDATE, ST_INTR} srs_state_t;
endpackage : srs_pkg

//--- srs_buf2.sv
`timescale 1ns/10ps
`default_nettype none
// two-entry fifo; flush empties it in one cycle
module srs_buf2
  import srs_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 flush,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [BUF_WIDTH-1:0] in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [BUF_WIDTH-1:0]      out_data
);
  logic [BUF_WIDTH-1:0] mem_r [BUF_DEPTH];
  logic                 wp_r;
  logic                 rp_r;
  logic [1:0]           cnt_r;
  logic                 push;
  logic                 pop;

  assign in_ready  = (cnt_r != 2'(BUF_DEPTH));
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else if (flush) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop)  rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : srs_buf2
`default_nettype wire

//--- srs_sub_flags.sv
`timescale 1ns/10ps
`default_nettype none
// a minus b, returning the six arithmetic flags for byte or word width
module srs_sub_flags
  import srs_pkg::*;
(
  input  wire logic [15:0] a,
  input  wire logic [15:0] b,
  input  wire logic        word,
  output logic [5:0]       flags
);
  logic [16:0] diff;
  logic [7:0]  low;
  logic        sign_a;
  logic        sign_b;
  logic        sign_d;

  assign diff   = {1'b0, a} - {1'b0, b};
  assign low    = diff[7:0];
  assign sign_a = word ? a[15] : a[7];
  assign sign_b = word ? b[15] : b[7];
  assign sign_d = word ? diff[15] : diff[7];

  // byte results ignore the upper half of both operands
  always_comb begin
    flags            = 6'h00;
    flags[FLG_CARRY] = word ? diff[16] : (a[7:0] < b[7:0]);
    flags[FLG_PAR]   = ~^low;
    flags[FLG_AUX]   = (a[3:0] < b[3:0]);
    flags[FLG_ZERO]  = word ? (diff[15:0] == 16'h0000) : (low == 8'h00);
    flags[FLG_SIGN]  = sign_d;
    flags[FLG_OVF]   = (sign_a != sign_b) && (sign_d != sign_a);
  end
endmodule : srs_sub_flags
`default_nettype wire

//--- srs_seq_props.sv
`timescale 1ns/10ps
`default_nettype none
// one clock domain, so one default clocking
module srs_seq_chk
  import srs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        code_req,
  input wire logic [19:0] code_addr,
  input wire logic        xfer_valid,
  input wire logic [15:0] xfer_code_base,
  input wire logic [15:0] xfer_instr_offset,
  input wire logic        xfer_intr_group,
  input wire logic [5:0]  xfer_flags,
  input wire logic        queue_flush,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [1:0]  mem_seg,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_word,
  input wire logic        mem_ack,
  input wire logic        bus_hold,
  input wire logic        reg_load,
  input wire logic        direction_flag,
  input wire logic        intr_enable,
  input wire logic        intr_req,
  input wire logic        nmi_req,
  input wire logic        intr_take,
  input wire logic [15:0] dest_index,
  input wire logic [15:0] repeat_counter,
  input wire logic [5:0]  flags,
  input wire logic        busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // transfer side
  a_xfer_flush: assert property (xfer_valid |-> queue_flush && !code_req)
    else $error("no queue flush");
  a_fetch_addr: assert property (xfer_valid |=> code_addr ==
    ({$past(xfer_code_base), 4'h0} + {4'h0, $past(xfer_instr_offset)}))
    else $error("bad fetch address");
  a_xfer_flags: assert property (xfer_valid && !reg_load && !busy |=>
    flags == ($past(xfer_intr_group) ? $past(xfer_flags) : $past(flags)))
    else $error("bad transfer flags");
  // element side
  a_dest_write: assert property (mem_req && mem_we |->
    mem_seg == SEG_EXTRA && mem_addr == dest_index)
    else $error("write off destination");
  a_req_stands: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_seg) && $stable(mem_we))
    else $error("request not held");
  a_count_step: assert property ($changed(repeat_counter) && !$past(reg_load) |->
    repeat_counter == $past(repeat_counter) - 16'h0001)
    else $error("bad counter step");
  a_index_step: assert property ($changed(dest_index) && !$past(reg_load) |->
    dest_index == $past(dest_index) + ($past(direction_flag) ?
    ($past(mem_word) ? 16'hFFFE : 16'hFFFF) : ($past(mem_word) ? STEP_WORD : STEP_BYTE)))
    else $error("bad index step");
  // interrupts between elements
  a_intr_gate: assert property (intr_take |-> busy && repeat_counter != 16'h0000 &&
    (nmi_req || (intr_req && intr_enable)))
    else $error("interrupt without cause");
  a_hold_drop: assert property (intr_take |=> !bus_hold [*8])
    else $error("hold after interrupt");
  a_hold_req: assert property (bus_hold |-> mem_req)
    else $error("hold without request");
  c_nmi: cover property (intr_take && nmi_req && !intr_enable);
  c_write: cover property (mem_req && mem_ack && mem_we);
  c_group: cover property (xfer_valid && xfer_intr_group);
endmodule : srs_seq_chk
bind srs_seq srs_seq_chk u_chk (.*);
`default_nettype wire

//--- srs_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// system memory behind the fetch and element ports
module srs_mem_model
  import srs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        code_req,
  input  wire logic [19:0] code_addr,
  output logic             code_ack,
  output logic [7:0]       code_data,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [1:0]  mem_seg,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_word,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [7:0] cmem [0:255];
  logic [7:0] dmem [0:1023];
  logic [2:0] wait_r;
  logic [9:0] a0, a1;
  assign a0 = {mem_seg, mem_addr[7:0]};
  assign a1 = {mem_seg, mem_addr[7:0] + 8'h01};
  // off-cycle data is scrambled so stale values never look right
  assign code_ack  = code_req;
  assign code_data = code_req ? cmem[code_addr[7:0]] : ~cmem[code_addr[7:0]];
  assign mem_ack   = mem_req && (wait_r == (slow ? 3'h3 : 3'h0));
  assign mem_rdata = mem_ack ? {dmem[a1], dmem[a0]} : ~{dmem[a1], dmem[a0]};
  // wait counter for the slow answer
  always @(posedge clk) wait_r <= (!mem_req || mem_ack) ? 3'h0 : wait_r + 3'h1;
  // writes land at the accepting edge
  always @(posedge clk) begin
    if (mem_ack && mem_we) begin
      dmem[a0] <= mem_wdata[7:0];
      if (mem_word) dmem[a1] <= mem_wdata[15:8];
    end
  end
endmodule : srs_mem_model
`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import srs_pkg::*;
  logic        clk, rst_n, slow, code_req, code_ack, xfer_valid, xfer_intr_group, queue_flush;
  logic        mem_req, mem_we, mem_word, bus_hold, mem_ack, reg_load, direction_flag;
  logic        intr_enable, intr_req, nmi_req, intr_take, intr_done, busy, other_op;
  logic [7:0]  code_data, other_byte;
  logic [19:0] code_addr;
  logic [15:0] xfer_code_base, xfer_instr_offset, mem_addr, mem_wdata, mem_rdata;
  logic [15:0] load_source_index, load_dest_index, load_repeat_counter, load_accum_word;
  logic [15:0] source_index, dest_index, repeat_counter, accum_word, code_base, instr_offset;
  logic [5:0]  xfer_flags, load_flags, flags;
  logic [1:0]  mem_seg, irq_mode;
  logic [2:0]  done_cnt;
  int          errors, cmp_count, cycles, takes;

  srs_seq DUT (.*);
  srs_mem_model P (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // interrupt source, done three cycles after take
  always @(posedge clk) begin
    intr_done <= (done_cnt == 3'h1);
    if (intr_take === 1'b1) begin
      {intr_req, nmi_req, irq_mode, done_cnt} <= {4'h0, 3'h3};
      takes <= takes + 1;
    end else begin
      done_cnt <= (done_cnt == 3'h0) ? 3'h0 : done_cnt - 3'h1;
      if (irq_mode == 2'h2 && mem_ack && mem_we) intr_req <= 1'b1;
    end
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic regs(input logic [15:0] s, d, c, a, input logic [5:0] f);
    check("source_index", source_index, s);
    check("dest_index", dest_index, d);
    check("repeat_counter", repeat_counter, c);
    check("accum_word", accum_word, a);
    check("flags", flags, f);
  endtask : regs

  // loads code at 0x40 and registers, then jumps there
  task automatic run(input logic [23:0] prog, input int n, input logic [15:0] cx, si, di, ax,
                     input logic [5:0] f, input logic df, input logic [1:0] irq);
    int k;
    for (int i = 0; i < n; i++) P.cmem[8'h40 + i] = prog[8 * (n - 1 - i) +: 8];
    P.cmem[8'h40 + n] = 8'hCC;
    @(posedge clk);
    {reg_load, direction_flag, irq_mode} <= {1'b1, df, irq};
    {load_repeat_counter, load_source_index, load_dest_index, load_accum_word} <= {cx, si, di, ax};
    {load_flags, nmi_req, intr_enable} <= {f, irq == 2'h1, irq == 2'h2};
    @(posedge clk);
    {reg_load, xfer_valid, xfer_code_base, xfer_instr_offset} <= {2'b01, 16'h0003, 16'h0010};
    @(posedge clk);
    xfer_valid <= 1'b0;
    #1 check("code_addr", code_addr, 20'h00040);
    k = 0;
    while (!(other_op === 1'b1 && other_byte === 8'hCC) && k < 400) @(posedge clk) #1 k++;
    check("finished", k < 400, 1'b1);
    for (int i = 0; i < 16; i++) P.cmem[8'h40 + i] = 8'h90;
  endtask : run

  initial begin
    {rst_n, slow, xfer_valid, xfer_intr_group, reg_load, direction_flag} = '0;
    {intr_enable, intr_req, nmi_req, intr_done, irq_mode, done_cnt} = '0;
    {xfer_code_base, xfer_instr_offset, xfer_flags, load_flags} = '0;
    {load_source_index, load_dest_index, load_repeat_counter, load_accum_word} = '0;
    {errors, cmp_count, cycles, takes} = '0;
    for (int i = 0; i < 256; i++) P.cmem[i] = 8'h90;
    for (int i = 0; i < 1024; i++) P.dmem[i] = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // held repeated byte move, interrupted after one write
    for (int i = 0; i < 3; i++) P.dmem[10'h310 + i] = 8'h11 * (i + 1);
    run(24'hF0F3A4, 3, 16'h0003, 16'h0010, 16'h0020, 16'h0000, 6'h15, 1'b0, 2'h2);
    for (int i = 0; i < 3; i++) check("moved", P.dmem[10'h020 + i], 8'h11 * (i + 1));
    regs(16'h0013, 16'h0023, 16'h0000, 16'h0000, 6'h15);
    check("takes", takes, 1);
    // repeated word store going down, slow memory
    slow = 1'b1;
    run(24'h00F3AB, 2, 16'h0002, 16'h0000, 16'h0040, 16'hBEEF, 6'h00, 1'b1, 2'h0);
    check("store", {P.dmem[10'h3F], P.dmem[10'h3E], P.dmem[10'h41], P.dmem[10'h40]},
          32'hBEEFBEEF);
    regs(16'h0000, 16'h003C, 16'h0000, 16'hBEEF, 6'h00);
    slow = 1'b0;
    // zero count performs nothing
    run(24'h00F3AA, 2, 16'h0000, 16'h0000, 16'h0050, 16'h0077, 6'h00, 1'b0, 2'h0);
    check("zero count", P.dmem[10'h050], 8'h00);
    regs(16'h0000, 16'h0050, 16'h0000, 16'h0077, 6'h00);
    // compare while equal stops on element three, zero flag clear
    for (int i = 0; i < 3; i++) P.dmem[10'h360 + i] = i + 1;
    for (int i = 0; i < 3; i++) P.dmem[10'h060 + i] = (i == 2) ? 9 : i + 1;
    run(24'h00F3A6, 2, 16'h0005, 16'h0060, 16'h0060, 16'h0000, 6'h00, 1'b0, 2'h0);
    regs(16'h0063, 16'h0063, 16'h0002, 16'h0000, 6'h17);
    // scan while unequal stops on the match, zero flag set
    for (int i = 0; i < 3; i++) P.dmem[10'h070 + i] = (i == 2) ? 8'h41 : 8'h10 * (i + 1);
    run(24'h00F2AE, 2, 16'h0005, 16'h0099, 16'h0070, 16'h0041, 6'h08, 1'b0, 2'h0);
    regs(16'h0099, 16'h0073, 16'h0002, 16'h0041, 6'h0A);
    // unprefixed word load from the data segment
    {P.dmem[10'h381], P.dmem[10'h380]} = 16'h1234;
    run(24'h0000AD, 1, 16'h0007, 16'h0080, 16'h0011, 16'h0000, 6'h00, 1'b0, 2'h0);
    regs(16'h0082, 16'h0011, 16'h0007, 16'h1234, 6'h00);
    // override before repeat, nmi with maskable ones off
    {P.dmem[10'h091], P.dmem[10'h090], P.dmem[10'h391], P.dmem[10'h390]} = 32'hE1E0D1D0;
    run(24'h26F3A4, 3, 16'h0002, 16'h0090, 16'h00A0, 16'h0000, 6'h00, 1'b0, 2'h1);
    check("override dropped", {P.dmem[10'h0A1], P.dmem[10'h0A0]}, 16'hD1D0);
    check("takes", takes, 2);
    // override honoured on an uninterrupted byte load
    {P.dmem[10'h0B0], P.dmem[10'h3B0]} = 16'h5AA5;
    run(24'h0026AC, 2, 16'h0000, 16'h00B0, 16'h0000, 16'hFF00, 6'h00, 1'b0, 2'h0);
    regs(16'h00B1, 16'h0000, 16'h0000, 16'hFF5A, 6'h00);
    // interrupt-group transfer loads flags and redirects
    @(posedge clk);
    {xfer_valid, xfer_intr_group, xfer_flags, xfer_instr_offset} <= {2'b11, 6'h2A, 16'h0030};
    @(posedge clk);
    {xfer_valid, xfer_intr_group} <= 2'b00;
    #1 check("xfer flags", flags, 6'h2A);
    check("xfer addr", code_addr, 20'h00060);
    check("xfer regs", {code_base, instr_offset}, 32'h00030030);
    print_verdict;
  end
endmodule : tb
`default_nettype wire
